// ### verilog/srq_cfg.svh
// constants of the service request enable logic
`ifndef SRQ_CFG_SVH
`define SRQ_CFG_SVH
// ************************************************
// bit positions
// ************************************************
`define SRQ_BIT_HW1 0
`define SRQ_BIT_HW2 1
`define SRQ_BIT_QUES 3
`define SRQ_BIT_MAV 4
`define SRQ_BIT_ESB 5
`define SRQ_BIT_RQS 6
`define SRQ_BIT_OPER 7
`define SRQ_CDMA_CONN_BIT 3
`define SRQ_OPER_CDMA_BIT 8
// ************************************************
// values
// ************************************************
`define SRQ_MASK_RESET 8'h00
`define SRQ_MASK_KEEP 8'hBF
`define SRQ_MASK_MAX 16'sh00FF
`define SRQ_ERR_RANGE 16'shFF22
`endif

// ### verilog/srq_pkg.sv
// types of the service request enable logic
package srq_pkg;
    typedef logic [7:0] srq_byte_t;
    typedef enum logic [1:0] {
        SRQ_IDLE = 2'h0,
        SRQ_REQ = 2'h1
    } srq_state_t;
endpackage

// ### verilog/srq_edge_latch.sv
// sticky event latch with selectable edge detection
`timescale 1ns/1ps
module srq_edge_latch (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cond,
    input wire logic pos_en,
    input wire logic neg_en,
    input wire logic clear,
    output logic event_flag
);
    logic prev;
    logic primed;
    // previous condition level
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prev <= 1'b0;
        end else begin
            prev <= cond;
        end
    end
    // primed once prev holds a real sample, so no false edge after reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            primed <= 1'b0;
        end else begin
            primed <= 1'b1;
        end
    end
    // set wins over clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            event_flag <= 1'b0;
        end else if (primed && ((neg_en && prev && !cond) || (pos_en && !prev && cond))) begin
            event_flag <= 1'b1;
        end else if (clear) begin
            event_flag <= 1'b0;
        end
    end
endmodule

// ### verilog/srq_enable_logic.sv
// service request enable mask, status byte and request flag
`timescale 1ns/1ps
`include "srq_cfg.svh"
module srq_enable_logic (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic mask_wr,
    input wire logic signed [15:0] mask_wr_value,
    input wire logic mask_rd,
    input wire logic stb_rd,
    input wire logic spoll,
    input wire logic hw1_summary,
    input wire logic hw2_summary,
    input wire logic ques_summary,
    input wire logic msg_avail,
    input wire logic esb_summary,
    input wire logic oper_other_summary,
    input wire logic [15:0] cdma_cond,
    input wire logic cdma_pos_en,
    input wire logic cdma_neg_en,
    input wire logic cdma_enable,
    input wire logic oper_cdma_enable,
    input wire logic cdma_event_clear,
    output logic [7:0] service_request_mask,
    output logic [7:0] resp_data,
    output logic resp_valid,
    output logic signed [15:0] err_code,
    output logic err_valid,
    output logic srq,
    output logic cdma_event
);
    srq_pkg::srq_byte_t status_byte;
    srq_pkg::srq_state_t rqs_state;
    logic mss;
    logic range_ok;
    logic group_summary_flag;
    logic oper_summary;
    logic rqs_flag;
    logic mss_prev;

    // ************************************************
    // cdma group and operation group path
    // ************************************************
    srq_edge_latch u_conn (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .cond(cdma_cond[`SRQ_CDMA_CONN_BIT]),
        .pos_en(cdma_pos_en),
        .neg_en(cdma_neg_en),
        .clear(cdma_event_clear),
        .event_flag(cdma_event)
    );
    // cdma summary only feeds the operation group
    assign group_summary_flag = cdma_event && cdma_enable;
    assign oper_summary = oper_other_summary || (group_summary_flag && oper_cdma_enable);

    // ************************************************
    // status byte and summary
    // ************************************************
    always_comb begin
        status_byte = 8'h00;
        status_byte[`SRQ_BIT_HW1] = hw1_summary;
        status_byte[`SRQ_BIT_HW2] = hw2_summary;
        status_byte[`SRQ_BIT_QUES] = ques_summary;
        status_byte[`SRQ_BIT_MAV] = msg_avail;
        status_byte[`SRQ_BIT_ESB] = esb_summary;
        status_byte[`SRQ_BIT_OPER] = oper_summary;
    end
    // masked OR, bit 6 excluded
    assign mss = |(status_byte & service_request_mask & `SRQ_MASK_KEEP);

    // ************************************************
    // mask register
    // ************************************************
    assign range_ok = (mask_wr_value >= 16'sh0000) && (mask_wr_value <= `SRQ_MASK_MAX);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            service_request_mask <= `SRQ_MASK_RESET;
        end else if (mask_wr && range_ok) begin
            service_request_mask <= mask_wr_value[7:0] & `SRQ_MASK_KEEP;
        end
    end
    // range error report
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            err_code <= 16'sh0000;
            err_valid <= 1'b0;
        end else begin
            err_valid <= mask_wr && !range_ok;
            if (mask_wr && !range_ok) begin
                err_code <= `SRQ_ERR_RANGE;
            end
        end
    end

    // ************************************************
    // request service flag
    // ************************************************
    assign rqs_flag = (rqs_state == srq_pkg::SRQ_REQ);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mss_prev <= 1'b0;
        end else begin
            mss_prev <= mss;
        end
    end
    // new reason sets, poll clears; set wins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rqs_state <= srq_pkg::SRQ_IDLE;
        end else begin
            unique case (rqs_state)
                srq_pkg::SRQ_IDLE: begin
                    if (mss && !mss_prev) begin
                        rqs_state <= srq_pkg::SRQ_REQ;
                    end
                end
                srq_pkg::SRQ_REQ: begin
                    if (spoll && !(mss && !mss_prev)) begin
                        rqs_state <= srq_pkg::SRQ_IDLE;
                    end
                end
                default: begin
                    rqs_state <= srq_pkg::SRQ_IDLE;
                end
            endcase
        end
    end
    assign srq = rqs_flag;

    // ************************************************
    // responses
    // ************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            resp_data <= 8'h00;
            resp_valid <= 1'b0;
        end else begin
            resp_valid <= mask_rd || stb_rd || spoll;
            if (mask_rd) begin
                resp_data <= service_request_mask;
            end else if (stb_rd) begin
                resp_data <= (status_byte & `SRQ_MASK_KEEP) | {1'b0, mss, 6'h00};
            end else if (spoll) begin
                resp_data <= (status_byte & `SRQ_MASK_KEEP) | {1'b0, rqs_flag, 6'h00};
            end
        end
    end

    // ************************************************
    // checks
    // ************************************************
    // mask contents and loading
    a_mask_bit6: assert property (@(posedge sys_clk) disable iff (!rstn)
        service_request_mask[`SRQ_BIT_RQS] == 1'b0)
        else $error("mask bit 6 set");
    a_mask_load: assert property (@(posedge sys_clk) disable iff (!rstn)
        mask_wr && range_ok |=> service_request_mask == ($past(mask_wr_value[7:0]) & `SRQ_MASK_KEEP))
        else $error("mask not loaded");
    a_mask_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        !mask_wr |=> $stable(service_request_mask))
        else $error("mask changed without write");

    // range error report
    a_range_err: assert property (@(posedge sys_clk) disable iff (!rstn)
        mask_wr && !range_ok |=> err_valid && err_code == `SRQ_ERR_RANGE && $stable(service_request_mask))
        else $error("range error missing");
    a_err_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        mask_wr && range_ok |=> !err_valid)
        else $error("error on legal write");
    a_err_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
        !mask_wr |=> !err_valid)
        else $error("error without write");

    // summary and request flag
    a_zero_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        service_request_mask == 8'h00 |-> !mss)
        else $error("summary with empty mask");
    a_masked_only: assert property (@(posedge sys_clk) disable iff (!rstn)
        mss |-> |(status_byte & service_request_mask))
        else $error("unmasked summary");
    a_srq_set: assert property (@(posedge sys_clk) disable iff (!rstn)
        mss && !mss_prev |=> srq)
        else $error("new reason not flagged");
    a_srq_reason: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(srq) |-> $past(mss))
        else $error("request without summary");
    a_poll_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        spoll && !mss |=> !srq)
        else $error("poll kept request");

    // answers to queries and polls
    a_mask_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        mask_rd |=> resp_valid && resp_data == $past(service_request_mask))
        else $error("mask read");
    a_resp_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
        !mask_rd && !stb_rd && !spoll |=> !resp_valid)
        else $error("answer without query");
    a_stb_mss: assert property (@(posedge sys_clk) disable iff (!rstn)
        stb_rd && !mask_rd |=> resp_data[`SRQ_BIT_RQS] == $past(mss))
        else $error("summary bit wrong");
    a_stb_bits: assert property (@(posedge sys_clk) disable iff (!rstn)
        stb_rd && !mask_rd |=> resp_data[`SRQ_BIT_MAV] == $past(msg_avail)
            && resp_data[`SRQ_BIT_HW2] == $past(hw2_summary))
        else $error("status byte bits wrong");
    a_poll_bit6: assert property (@(posedge sys_clk) disable iff (!rstn)
        spoll && !mask_rd && !stb_rd |=> resp_data[`SRQ_BIT_RQS] == $past(srq))
        else $error("poll request bit wrong");
    a_poll_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
        spoll && !mask_rd && !stb_rd |=> (resp_data & `SRQ_MASK_KEEP) == ($past(status_byte) & `SRQ_MASK_KEEP))
        else $error("poll status bits wrong");

    // cdma event path
    a_cdma_route: assert property (@(posedge sys_clk) disable iff (!rstn)
        !oper_cdma_enable && !oper_other_summary |-> !status_byte[`SRQ_BIT_OPER])
        else $error("cdma bypassed operation group");
    a_oper_path: assert property (@(posedge sys_clk) disable iff (!rstn)
        !cdma_event && !oper_other_summary |-> !status_byte[`SRQ_BIT_OPER])
        else $error("operation bit without source");
    a_fall_event: assert property (@(posedge sys_clk) disable iff (!rstn)
        cdma_neg_en && $past(rstn) && $fell(cdma_cond[`SRQ_CDMA_CONN_BIT]) |=> cdma_event)
        else $error("fall not latched");
    a_rise_event: assert property (@(posedge sys_clk) disable iff (!rstn)
        cdma_pos_en && $past(rstn) && $rose(cdma_cond[`SRQ_CDMA_CONN_BIT]) |=> cdma_event)
        else $error("rise not latched");
endmodule

// ### tb/srq_ctrl_model.sv
// bus controller model sending mask and status commands
`timescale 1ns/1ps
module srq_ctrl_model (
    input wire logic sys_clk,
    output logic mask_wr,
    output logic signed [15:0] mask_wr_value,
    output logic mask_rd,
    output logic stb_rd,
    output logic spoll
);
    initial begin
        {mask_wr, mask_rd, stb_rd, spoll} = 4'h0;
        mask_wr_value = 16'sh0000;
    end
    // one command pulse: 0 write, 1 mask query, 2 status query, 3 poll
    task automatic send(input int kind, input logic signed [15:0] v);
        @(posedge sys_clk);
        mask_wr_value <= v; // sum of wanted weights, zero disables
        mask_wr <= (kind == 0);
        mask_rd <= (kind == 1);
        stb_rd <= (kind == 2);
        spoll <= (kind == 3);
        @(posedge sys_clk);
        {mask_wr, mask_rd, stb_rd, spoll} <= 4'h0;
        mask_wr_value <= ~v; // stale value must not linger
    endtask
endmodule

// ### tb/testbench.sv
// self-checking bench of the service request enable logic
`timescale 1ns/1ps
module testbench;
    logic sys_clk, rstn, hw1, hw2, ques, mav, esb, oper, pos_en, neg_en, cdma_en, oper_en, clr;
    logic [15:0] cond;
    logic mask_wr, mask_rd, stb_rd, spoll, resp_valid, err_valid, srq, cdma_event;
    logic signed [15:0] mask_wr_value, err_code;
    logic [7:0] mask, resp_data;
    int failures, compares;
    logic [15:0] wv[5] = '{16'h00FF, 16'h0040, 16'h0080, 16'h0000, 16'h0012};
    logic [7:0] wm[5] = '{8'hBF, 8'h00, 8'h80, 8'h00, 8'h12};
    srq_ctrl_model u_ctrl (.sys_clk(sys_clk), .mask_wr(mask_wr), .mask_wr_value(mask_wr_value),
        .mask_rd(mask_rd), .stb_rd(stb_rd), .spoll(spoll));
    srq_enable_logic u_dut (.sys_clk(sys_clk), .rstn(rstn), .mask_wr(mask_wr), .mask_wr_value(mask_wr_value),
        .mask_rd(mask_rd), .stb_rd(stb_rd), .spoll(spoll), .hw1_summary(hw1), .hw2_summary(hw2),
        .ques_summary(ques), .msg_avail(mav), .esb_summary(esb), .oper_other_summary(oper),
        .cdma_cond(cond), .cdma_pos_en(pos_en), .cdma_neg_en(neg_en), .cdma_enable(cdma_en),
        .oper_cdma_enable(oper_en), .cdma_event_clear(clr), .service_request_mask(mask),
        .resp_data(resp_data), .resp_valid(resp_valid), .err_code(err_code), .err_valid(err_valid),
        .srq(srq), .cdma_event(cdma_event));
    // ************************************************
    // clock and checking helpers
    // ************************************************
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // bounded wait for srq (0) or cdma_event (1) to go high
    task automatic wait_hi(input int which);
        for (int i = 0; i < 10; i++) begin
            @(negedge sys_clk);
            if ((which ? cdma_event : srq) === 1'b1) return;
        end
        chk("wait", 16'h0001, 16'h0000);
        end_sim();
    endtask
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        {rstn, hw1, hw2, ques, mav, esb, oper, pos_en, neg_en, cdma_en, oper_en, clr} = 12'h000;
        cond = 16'h0008;
        failures = 0;
        compares = 0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(negedge sys_clk);
        chk("mask", 16'h0000, {8'h00, mask});
        for (int i = 0; i < 5; i++) begin
            u_ctrl.send(0, wv[i]);
            u_ctrl.send(1, 16'sh0000);
            @(negedge sys_clk);
            chk("resp", {15'h0000, 1'b1}, {15'h0000, resp_valid});
            chk("query", {8'h00, wm[i]}, {8'h00, resp_data});
        end
        for (int i = 0; i < 2; i++) begin
            u_ctrl.send(0, i ? 16'sh0100 : -16'sh0001);
            @(negedge sys_clk);
            chk("err", 16'hFF22, err_code & {16{err_valid}});
            chk("mask", 16'h0012, {8'h00, mask});
        end
        @(posedge sys_clk);
        mav <= 1'b1;
        wait_hi(0);
        u_ctrl.send(2, 16'sh0000);
        @(negedge sys_clk);
        chk("stb", 16'h0050, {8'h00, resp_data});
        u_ctrl.send(3, 16'sh0000);
        @(negedge sys_clk);
        chk("poll", 16'h0050, {8'h00, resp_data});
        chk("srq", 16'h0000, {15'h0000, srq});
        u_ctrl.send(0, 16'sh0000);
        {hw1, mav, hw2, ques, esb} <= 5'h1F;
        repeat (8) @(negedge sys_clk) chk("srq", 16'h0000, {15'h0000, srq});
        u_ctrl.send(2, 16'sh0000);
        @(negedge sys_clk);
        chk("stb", 16'h003B, {8'h00, resp_data});
        {neg_en, cdma_en, oper_en, mav} <= 4'hE;
        u_ctrl.send(0, 16'sh0080);
        cond <= 16'h0000;
        wait_hi(1);
        wait_hi(0);
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("event", 16'h0000, {15'h0000, cdma_event});
        // rising edge selection, then a reset in mid-run
        @(posedge sys_clk);
        {pos_en, neg_en} <= 2'b10;
        cond <= 16'h0008;
        wait_hi(1);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("mask", 16'h0000, {8'h00, mask});
        chk("srq", 16'h0000, {15'h0000, srq});
        chk("event", 16'h0000, {15'h0000, cdma_event});
        u_ctrl.send(0, 16'sh00C0);
        oper <= 1'b1;
        wait_hi(0);
        u_ctrl.send(1, 16'sh0000);
        @(negedge sys_clk);
        chk("query", 16'h0080, {8'h00, resp_data});
        end_sim();
    end
endmodule
